// ===== src/ssr_pkg.sv
// Purpose: Constants for the status and event register block.
// Assumes: 100 MHz clock; registers reached by a decoded query port.
// Notes: No logic here; operating rules listed below.
// Operation
// - Operation complete after earlier commands finish
// - Query error on orphan read or overrun
// - Device fault sets bit 3, queues code
// - Execution failure sets bit 4, queues code
// - Malformed command sets bit 5, queues code
// - Manual control switch sets bit 6
// - Power on sets bit 7
// - Event register readable, enable register read/write
// - Summaries for calibrate, measure, trigger at 0,4,5
// - Summaries for init, low, high at 10,11,12
// - Each group has condition and event views
// - Calibrating condition bit 1 during calibration
// - Calibrating event records start or completion
// - Measuring condition bit 1 while measuring
// - Measuring event records start or completion
// - Trigger wait bit 1; trigger enters measuring
// - Trigger event records any wait
// - Init bit 1 after power, connect, reset, preset
// - Init event records start or completion
// - Below limit condition and event
// - Above limit condition and event
// - Poll mask ANDed with status byte, ORed
package ssr_pkg;
    // Clock and initialization timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Standard event bit positions
    localparam int EVB_OPC = 0;
    localparam int EVB_QUERY = 2;
    localparam int EVB_DEVICE = 3;
    localparam int EVB_EXEC = 4;
    localparam int EVB_CMD = 5;
    localparam int EVB_USER = 6;
    localparam int EVB_PWR = 7;
    // Reset values
    localparam logic [7:0] EVENT_RESET = 8'h80;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] POLL_MASK_RESET = 8'h00;
    // Group indices and the summary position of each
    localparam int NUM_GROUPS = 6;
    localparam int GRP_CAL = 0;
    localparam int GRP_MEAS = 1;
    localparam int GRP_TRIG = 2;
    localparam int GRP_INIT = 3;
    localparam int GRP_LOW = 4;
    localparam int GRP_HIGH = 5;
    localparam int SUM_POS [NUM_GROUPS] = '{0, 4, 5, 10, 11, 12};
    // Active bit inside every group register
    localparam int GRP_BIT = 1;
    // Query port register selects
    localparam logic [4:0] SEL_EVENT = 5'h00;
    localparam logic [4:0] SEL_ENABLE = 5'h01;
    localparam logic [4:0] SEL_OP_COND = 5'h02;
    localparam logic [4:0] SEL_OP_EVENT = 5'h03;
    localparam logic [4:0] SEL_GRP_COND = 5'h04;
    localparam logic [4:0] SEL_GRP_EVENT = 5'h0A;
    localparam logic [4:0] SEL_POLL_MASK = 5'h10;
    // Error codes queued for each error class
    localparam logic signed [15:0] ERR_DEVICE = -16'sd300;
    localparam logic signed [15:0] ERR_DEVICE_LOW = -16'sd399;
    localparam logic signed [15:0] ERR_EXEC = -16'sd200;
    localparam logic signed [15:0] ERR_CMD = -16'sd100;
    // Trigger sequencing states
    typedef enum logic [1:0] {SSR_IDLE, SSR_WAIT, SSR_MEASURE} ssr_trig_state_t;
endpackage

// ===== src/ssr_status.sv
// Purpose: Standard event and operation status reporting registers.
// Assumes: All event inputs come from logic on clk; queries decoded upstream.
// Notes: Reads return data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module ssr_status #(
    parameter int INIT_CNT_W = 8,
    parameter int VALUE_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Query port from the command interpreter
    input wire logic [4:0] reg_sel,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // Command sequencing events
    input wire logic opc_cmd,
    input wire logic exec_busy,
    input wire logic clear_cmd,
    input wire logic resp_ready,
    input wire logic resp_fetch,
    input wire logic cmd_recv,
    // Error events
    input wire logic dev_fault,
    input wire logic signed [15:0] dev_err_code,
    input wire logic exec_fail,
    input wire logic cmd_malformed,
    input wire logic manual_req,
    // Error queue feed
    output logic err_valid,
    output logic signed [15:0] err_code,
    // Activity inputs
    input wire logic cal_active,
    input wire logic meas_arm,
    input wire logic trig_event,
    input wire logic meas_done,
    input wire logic meas_abort,
    input wire logic reset_cmd,
    input wire logic preset_cmd,
    input wire logic connect_evt,
    // Limit checking
    input wire logic result_valid,
    input wire logic signed [VALUE_W-1:0] meas_value,
    input wire logic signed [VALUE_W-1:0] lower_limit,
    input wire logic signed [VALUE_W-1:0] upper_limit,
    // Status byte and summaries
    input wire logic [7:0] status_byte,
    output logic event_summary,
    output logic individual_status_flag
);
    // Parameter checks
    initial begin
        if (INIT_CNT_W < 2 || ssr_pkg::INIT_CYCLES >= (1 << INIT_CNT_W)) begin
            $error("INIT_CNT_W too small for initialization count");
        end
        if (VALUE_W < 2) begin
            $error("VALUE_W must be at least 2");
        end
    end

    localparam logic [INIT_CNT_W-1:0] INIT_LOAD = INIT_CNT_W'(ssr_pkg::INIT_CYCLES);

    // Status state
    logic [7:0] event_reg, event_next; // Standard event register
    logic [7:0] enable_reg, enable_next; // Standard event enable mask
    logic [7:0] poll_mask_reg, poll_mask_next; // Parallel poll mask
    logic opc_pend_reg, opc_pend_next; // Waiting for busy to drop
    logic resp_pend_reg, resp_pend_next; // Response data not yet fetched
    logic [INIT_CNT_W-1:0] init_cnt_reg, init_cnt_next; // Initialization timer
    logic below_reg, below_next; // Value below lower limit
    logic above_reg, above_next; // Value above upper limit
    logic [ssr_pkg::NUM_GROUPS-1:0] cond_reg, cond_next; // Group condition views
    logic [ssr_pkg::NUM_GROUPS-1:0] gevt_reg, gevt_next; // Group event views
    ssr_pkg::ssr_trig_state_t trig_state_reg, trig_state_next; // Trigger sequencing state
    logic err_valid_next;
    logic signed [15:0] err_code_next;
    logic esb_next;
    logic ist_next;

    // Helper terms
    logic [ssr_pkg::NUM_GROUPS-1:0] cond_now; // Present state of each group
    logic [ssr_pkg::NUM_GROUPS-1:0] gevt_set; // Group event set terms
    logic [15:0] op_cond; // Operation condition summary
    logic [15:0] op_event; // Operation event summary
    logic rd_event, rd_op_event, cls;
    logic [7:0] ev_set;
    logic opc_want;
    logic dev_code_ok;

    // Strobes that clear event views
    assign rd_event = reg_rd && reg_sel == ssr_pkg::SEL_EVENT;
    assign rd_op_event = reg_rd && reg_sel == ssr_pkg::SEL_OP_EVENT;
    assign cls = clear_cmd;

    // Present condition of each group
    // calibration in progress
    assign cond_now[ssr_pkg::GRP_CAL] = cal_active;
    assign cond_now[ssr_pkg::GRP_MEAS] = trig_state_reg == ssr_pkg::SSR_MEASURE;
    assign cond_now[ssr_pkg::GRP_TRIG] = trig_state_reg == ssr_pkg::SSR_WAIT;
    assign cond_now[ssr_pkg::GRP_INIT] = init_cnt_reg != '0;
    assign cond_now[ssr_pkg::GRP_LOW] = below_reg;
    assign cond_now[ssr_pkg::GRP_HIGH] = above_reg;

    // Per-group event set and summary bits
    genvar g;
    generate
        for (g = 0; g < ssr_pkg::NUM_GROUPS; g++) begin : gen_grp
            if (g == ssr_pkg::GRP_TRIG || g == ssr_pkg::GRP_LOW ||
                g == ssr_pkg::GRP_HIGH) begin : gen_lvl
                // any wait or limit violation is recorded
                assign gevt_set[g] = cond_now[g];
            end else begin : gen_edge
                // start or completion is a change
                assign gevt_set[g] = cond_now[g] != cond_reg[g];
            end
            assign op_cond[ssr_pkg::SUM_POS[g]] = cond_reg[g];
            assign op_event[ssr_pkg::SUM_POS[g]] = gevt_reg[g];
        end
    endgenerate
    // Unused summary positions read as zero
    assign op_cond[3:1] = '0;
    assign op_cond[9:6] = '0;
    assign op_cond[15:13] = '0;
    assign op_event[3:1] = '0;
    assign op_event[9:6] = '0;
    assign op_event[15:13] = '0;

    // Device code accepted only in its documented range
    assign dev_code_ok = (dev_err_code > 16'sd0) ||
        (dev_err_code <= ssr_pkg::ERR_DEVICE && dev_err_code >= ssr_pkg::ERR_DEVICE_LOW);
    assign opc_want = opc_pend_reg || opc_cmd;

    // Next state of all status registers
    always_comb begin
        ev_set = '0;
        // operation complete once nothing is executing
        ev_set[ssr_pkg::EVB_OPC] = opc_want && !exec_busy;
        opc_pend_next = opc_want && exec_busy;
        // orphan fetch or new command over pending data
        ev_set[ssr_pkg::EVB_QUERY] = (resp_fetch && !resp_pend_reg) || (cmd_recv && resp_pend_reg);
        ev_set[ssr_pkg::EVB_DEVICE] = dev_fault;
        ev_set[ssr_pkg::EVB_EXEC] = exec_fail;
        ev_set[ssr_pkg::EVB_CMD] = cmd_malformed;
        ev_set[ssr_pkg::EVB_USER] = manual_req;
        // Pending response: fetch or new command discards it
        if (resp_ready) begin
            resp_pend_next = 1'b1;
        end else if (resp_fetch || cmd_recv) begin
            resp_pend_next = 1'b0;
        end else begin
            resp_pend_next = resp_pend_reg;
        end
        // read clears, a set in the same cycle wins
        event_next = ((rd_event || cls) ? 8'h00 : event_reg) | ev_set;
        enable_next = enable_reg;
        poll_mask_next = poll_mask_reg;
        if (reg_wr && reg_sel == ssr_pkg::SEL_ENABLE) begin
            enable_next = reg_wdata[7:0];
        end
        if (reg_wr && reg_sel == ssr_pkg::SEL_POLL_MASK) begin
            poll_mask_next = reg_wdata[7:0];
        end
        // error code priority: device, then execution, then command
        err_valid_next = dev_fault || exec_fail || cmd_malformed;
        if (dev_fault) begin
            err_code_next = dev_code_ok ? dev_err_code : ssr_pkg::ERR_DEVICE;
        end else if (exec_fail) begin
            err_code_next = ssr_pkg::ERR_EXEC;
        end else if (cmd_malformed) begin
            err_code_next = ssr_pkg::ERR_CMD;
        end else begin
            err_code_next = err_code;
        end
        // restart initialization on reset, preset or connect
        if (reset_cmd || preset_cmd || connect_evt) begin
            init_cnt_next = INIT_LOAD;
        end else if (init_cnt_reg != '0) begin
            init_cnt_next = init_cnt_reg - 1'b1;
        end else begin
            init_cnt_next = init_cnt_reg;
        end
        below_next = result_valid ? (meas_value < lower_limit) : below_reg;
        above_next = result_valid ? (meas_value > upper_limit) : above_reg;
        trig_state_next = trig_state_reg;
        unique case (trig_state_reg)
            ssr_pkg::SSR_IDLE: begin
                if (meas_arm) begin
                    trig_state_next = ssr_pkg::SSR_WAIT;
                end
            end
            ssr_pkg::SSR_WAIT: begin
                if (meas_abort) begin
                    trig_state_next = ssr_pkg::SSR_IDLE;
                end else if (trig_event) begin
                    trig_state_next = ssr_pkg::SSR_MEASURE;
                end
            end
            ssr_pkg::SSR_MEASURE: begin
                if (meas_abort || meas_done) begin
                    trig_state_next = ssr_pkg::SSR_IDLE;
                end
            end
            default: begin
                trig_state_next = ssr_pkg::SSR_IDLE;
            end
        endcase
        cond_next = cond_now;
        // group events sticky; own read or summary read clears
        for (int i = 0; i < ssr_pkg::NUM_GROUPS; i++) begin
            if (cls || rd_op_event ||
                (reg_rd && reg_sel == ssr_pkg::SEL_GRP_EVENT + 5'(i))) begin
                gevt_next[i] = gevt_set[i];
            end else begin
                gevt_next[i] = gevt_reg[i] | gevt_set[i];
            end
        end
        // Event summary bit for the status byte
        esb_next = |(event_next & enable_next);
        ist_next = |(status_byte & poll_mask_reg);
    end

    // Status registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // power on is recorded at reset
            event_reg <= ssr_pkg::EVENT_RESET;
            enable_reg <= ssr_pkg::ENABLE_RESET;
            poll_mask_reg <= ssr_pkg::POLL_MASK_RESET;
            opc_pend_reg <= 1'b0;
            resp_pend_reg <= 1'b0;
            init_cnt_reg <= INIT_LOAD;
            below_reg <= 1'b0;
            above_reg <= 1'b0;
            cond_reg <= '0;
            gevt_reg <= '0;
            trig_state_reg <= ssr_pkg::SSR_IDLE;
            err_valid <= 1'b0;
            err_code <= 16'sh0000;
            event_summary <= 1'b0;
            individual_status_flag <= 1'b0;
        end else begin
            event_reg <= event_next;
            enable_reg <= enable_next;
            poll_mask_reg <= poll_mask_next;
            opc_pend_reg <= opc_pend_next;
            resp_pend_reg <= resp_pend_next;
            init_cnt_reg <= init_cnt_next;
            below_reg <= below_next;
            above_reg <= above_next;
            cond_reg <= cond_next;
            gevt_reg <= gevt_next;
            trig_state_reg <= trig_state_next;
            err_valid <= err_valid_next;
            err_code <= err_code_next;
            event_summary <= esb_next;
            individual_status_flag <= ist_next;
        end
    end

    // Read path next values
    logic [15:0] rd_data_next;
    logic [4:0] grp_idx;
    always_comb begin
        rd_data_next = 16'h0000;
        grp_idx = 5'h00;
        if (reg_sel == ssr_pkg::SEL_EVENT) begin
            rd_data_next = {8'h00, event_reg};
        end else if (reg_sel == ssr_pkg::SEL_ENABLE) begin
            rd_data_next = {8'h00, enable_reg};
        end else if (reg_sel == ssr_pkg::SEL_POLL_MASK) begin
            rd_data_next = {8'h00, poll_mask_reg};
        end else if (reg_sel == ssr_pkg::SEL_OP_COND) begin
            rd_data_next = op_cond;
        end else if (reg_sel == ssr_pkg::SEL_OP_EVENT) begin
            rd_data_next = op_event;
        end else if (reg_sel >= ssr_pkg::SEL_GRP_COND && reg_sel < ssr_pkg::SEL_GRP_EVENT) begin
            grp_idx = reg_sel - ssr_pkg::SEL_GRP_COND;
            rd_data_next[ssr_pkg::GRP_BIT] = cond_reg[grp_idx[2:0]];
        end else if (reg_sel >= ssr_pkg::SEL_GRP_EVENT &&
                     reg_sel < ssr_pkg::SEL_GRP_EVENT + 5'(ssr_pkg::NUM_GROUPS)) begin
            grp_idx = reg_sel - ssr_pkg::SEL_GRP_EVENT;
            rd_data_next[ssr_pkg::GRP_BIT] = gevt_reg[grp_idx[2:0]];
        end
    end

    // Read path registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_data <= reg_rd ? rd_data_next : rd_data;
            rd_valid <= reg_rd;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_trig_seen;
        trig_state_reg == ssr_pkg::SSR_WAIT && trig_event && !meas_abort;
    endsequence
    sequence s_measuring;
        trig_state_reg == ssr_pkg::SSR_MEASURE ##1 cond_reg[ssr_pkg::GRP_MEAS];
    endsequence

    a_opc_after_idle: assert property ($rose(event_reg[0]) |-> !$past(exec_busy))
        else $error("operation complete set while busy");
    a_query_error_set: assert property (resp_fetch && !resp_pend_reg |=> event_reg[2])
        else $error("orphan fetch not flagged");
    a_device_error: assert property (dev_fault |=> event_reg[3] && err_valid)
        else $error("device fault not recorded");
    a_exec_error: assert property (
        exec_fail && !dev_fault |=> event_reg[4] && err_code == ssr_pkg::ERR_EXEC)
        else $error("execution error not queued");
    a_cmd_error: assert property (
        cmd_malformed && !dev_fault && !exec_fail
        |=> event_reg[5] && err_code == ssr_pkg::ERR_CMD)
        else $error("command error not queued");
    a_user_request: assert property (manual_req |=> event_reg[6])
        else $error("user request not recorded");
    a_trig_to_meas: assert property (s_trig_seen |=> s_measuring)
        else $error("trigger did not start measuring");
    a_event_read_clr: assert property (
        rd_event && ev_set == 8'h00 |=> event_reg == 8'h00 && rd_valid)
        else $error("event register not cleared by read");
    a_summary_or: assert property (
        rd_op_event |=> rd_data[5] == $past(gevt_reg[2]) && rd_data[12] == $past(gevt_reg[5]))
        else $error("summary does not follow group event");
    a_poll_flag: assert property (
        1'b1 |=> individual_status_flag == |($past(status_byte) & $past(poll_mask_reg)))
        else $error("parallel poll flag wrong");

    // Group views, limit flags and mask writes
    a_enable_write: assert property (
        reg_wr && reg_sel == ssr_pkg::SEL_ENABLE |=> enable_reg == $past(reg_wdata[7:0]))
        else $error("enable mask write lost");
    a_cal_event: assert property (
        cal_active != cond_reg[ssr_pkg::GRP_CAL] |=> gevt_reg[ssr_pkg::GRP_CAL])
        else $error("calibration start or stop not recorded");
    a_meas_event: assert property (
        cond_now[ssr_pkg::GRP_MEAS] != cond_reg[ssr_pkg::GRP_MEAS]
        |=> gevt_reg[ssr_pkg::GRP_MEAS])
        else $error("measuring start or stop not recorded");
    a_init_event: assert property (
        cond_now[ssr_pkg::GRP_INIT] != cond_reg[ssr_pkg::GRP_INIT]
        |=> gevt_reg[ssr_pkg::GRP_INIT])
        else $error("initialization start or stop not recorded");
    sequence s_init_restart;
        init_cnt_reg == INIT_LOAD ##1 cond_reg[ssr_pkg::GRP_INIT];
    endsequence
    a_init_restart: assert property (
        reset_cmd || preset_cmd || connect_evt |=> s_init_restart)
        else $error("initialization did not restart");
    a_trig_wait_event: assert property (
        cond_now[ssr_pkg::GRP_TRIG] |=> gevt_reg[ssr_pkg::GRP_TRIG])
        else $error("trigger wait not recorded");
    a_below_limit: assert property (
        result_valid && meas_value < lower_limit |=> below_reg ##1 cond_reg[ssr_pkg::GRP_LOW])
        else $error("lower limit fail not shown");
    a_above_limit: assert property (
        result_valid && meas_value > upper_limit |=> above_reg ##1 cond_reg[ssr_pkg::GRP_HIGH])
        else $error("upper limit fail not shown");
endmodule
`default_nettype wire

// ===== test/ssr_status_bench.sv
// Purpose: Self-checking bench for the status and event register block.
// Assumes: Query port timing as handed over; inputs driven on falling edges.
// Notes: Random limits, masks and codes from a fixed seed, plus corner cases.
`timescale 1ns/1ps
`default_nettype none
module ssr_status_bench;
    // Clock, reset and query port
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] reg_sel = 5'h00;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] rd_data;
    logic rd_valid;
    // Pulse inputs packed in one vector
    logic [16:0] pv = '0;
    logic exec_busy = 1'b0;
    logic cal_active = 1'b0;
    logic signed [15:0] dev_err_code = '0;
    logic signed [15:0] meas_value = '0;
    logic signed [15:0] lower_limit = '0;
    logic signed [15:0] upper_limit = '0;
    logic [7:0] status_byte = 8'h00;
    // Outputs watched
    logic err_valid;
    logic signed [15:0] err_code;
    logic event_summary;
    logic isf;
    // Counters
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    ssr_status u_ssr_status (
        .clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .opc_cmd(pv[0]),
        .exec_busy(exec_busy), .clear_cmd(pv[1]), .resp_ready(pv[2]), .resp_fetch(pv[3]),
        .cmd_recv(pv[4]), .dev_fault(pv[5]), .dev_err_code(dev_err_code),
        .exec_fail(pv[6]), .cmd_malformed(pv[7]), .manual_req(pv[8]),
        .err_valid(err_valid), .err_code(err_code), .cal_active(cal_active),
        .meas_arm(pv[9]), .trig_event(pv[10]), .meas_done(pv[11]), .meas_abort(pv[12]),
        .reset_cmd(pv[13]), .preset_cmd(pv[14]), .connect_evt(pv[15]),
        .result_valid(pv[16]), .meas_value(meas_value), .lower_limit(lower_limit),
        .upper_limit(upper_limit), .status_byte(status_byte),
        .event_summary(event_summary), .individual_status_flag(isf)
    );

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    // Verdict and end of run
    task automatic summarize();
        $display("Counts: checks=%0d mismatches=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total = err_total + 1;
            summarize();
        end
    end

    // Compare seen against expected
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One-cycle pulse on a packed input
    task automatic pulse(input int k);
        @(negedge clk) pv[k] = 1'b1;
        @(negedge clk) pv[k] = 1'b0;
    endtask

    // Query read, answer one cycle later
    task automatic rd(input int sel, input logic [15:0] exp);
        @(negedge clk);
        reg_sel = 5'(sel);
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(rd_valid, 16'h0001);
        chk(rd_data, exp);
    endtask

    task automatic wr(input logic [4:0] sel, input logic [15:0] d);
        @(negedge clk);
        reg_sel = sel;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // Expected queued code for a device fault
    function automatic logic [15:0] dev_exp(input logic signed [15:0] c);
        if (c > 0 || (c >= -16'sd399 && c <= -16'sd300)) return c;
        return ssr_pkg::ERR_DEVICE;
    endfunction

    // Limit flags: bit 0 below, bit 1 above
    function automatic logic [1:0] lim_exp(input logic signed [15:0] v, lo, hi);
        return {v > hi, v < lo};
    endfunction

    initial begin
        logic signed [15:0] codes [4];
        logic [15:0] d;
        logic [7:0] m;
        logic [1:0] e;
        void'($urandom(40));
        tick(10);
        sys_rst = 1'b0;
        rd(ssr_pkg::SEL_GRP_COND + 3, 16'h0002);
        rd(ssr_pkg::SEL_EVENT, 16'h0080);
        rd(ssr_pkg::SEL_EVENT, 16'h0000);
        tick(ssr_pkg::INIT_CYCLES);
        rd(ssr_pkg::SEL_GRP_COND + 3, 16'h0000);
        rd(ssr_pkg::SEL_OP_EVENT, 16'h0400);
        rd(ssr_pkg::SEL_GRP_EVENT + 3, 16'h0000);
        // Restart causes of initialization
        for (int k = 13; k <= 15; k++) begin
            pulse(k);
            tick(2);
            rd(ssr_pkg::SEL_GRP_COND + 3, 16'h0002);
            rd(ssr_pkg::SEL_GRP_EVENT + 3, 16'h0002);
            tick(ssr_pkg::INIT_CYCLES);
        end
        $display("Test power-up and init finished");
        // Error classes and codes
        codes = '{-16'sd300 - 16'($urandom_range(0, 99)), 16'sd5, -16'sd50, -16'sd400};
        foreach (codes[i]) begin
            dev_err_code = codes[i];
            pulse(5);
            chk(err_valid, 16'h0001);
            chk(err_code, dev_exp(codes[i]));
            rd(ssr_pkg::SEL_EVENT, 16'h0008);
        end
        pulse(6);
        chk(err_code, ssr_pkg::ERR_EXEC);
        rd(ssr_pkg::SEL_EVENT, 16'h0010);
        pulse(7);
        chk(err_code, ssr_pkg::ERR_CMD);
        rd(ssr_pkg::SEL_EVENT, 16'h0020);
        // Three errors at once queue only the device code
        dev_err_code = 16'sh0007;
        @(negedge clk);
        pv[7:5] = 3'b111;
        @(negedge clk);
        pv[7:5] = 3'b000;
        chk(err_code, 16'h0007);
        rd(ssr_pkg::SEL_EVENT, 16'h0038);
        pulse(8);
        chk(err_valid, 16'h0000);
        rd(ssr_pkg::SEL_EVENT, 16'h0040);
        pulse(3);
        rd(ssr_pkg::SEL_EVENT, 16'h0004);
        pulse(2);
        pulse(4);
        rd(ssr_pkg::SEL_EVENT, 16'h0004);
        pulse(2);
        pulse(3);
        rd(ssr_pkg::SEL_EVENT, 16'h0000);
        exec_busy = 1'b1;
        pulse(0);
        tick(3);
        rd(ssr_pkg::SEL_EVENT, 16'h0000);
        exec_busy = 1'b0;
        tick(3);
        rd(ssr_pkg::SEL_EVENT, 16'h0001);
        $display("Test standard events finished");
        // Enable mask, summary, refused accesses
        d = 16'($urandom);
        wr(ssr_pkg::SEL_ENABLE, d);
        rd(ssr_pkg::SEL_ENABLE, {8'h00, d[7:0]});
        rd(5'h11, 16'h0000);
        wr(ssr_pkg::SEL_OP_COND, 16'hffff);
        rd(ssr_pkg::SEL_OP_COND, 16'h0000);
        wr(ssr_pkg::SEL_ENABLE, 16'h0010);
        pulse(6);
        tick(2);
        chk(event_summary, 16'h0001);
        pulse(7);
        pulse(1);
        rd(ssr_pkg::SEL_EVENT, 16'h0000);
        tick(2);
        chk(event_summary, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            m = (i == 0) ? 8'h40 : 8'($urandom);
            wr(ssr_pkg::SEL_POLL_MASK, {8'h00, m});
            status_byte = (i == 0) ? 8'h40 : 8'($urandom);
            tick(3);
            chk(isf, {15'h0000, |(m & status_byte)});
            rd(ssr_pkg::SEL_POLL_MASK, {8'h00, m});
        end
        $display("Test enable and poll finished");
        // Calibration and trigger sequencing
        cal_active = 1'b1;
        tick(3);
        rd(ssr_pkg::SEL_GRP_COND, 16'h0002);
        rd(ssr_pkg::SEL_OP_COND, 16'h0001);
        cal_active = 1'b0;
        tick(3);
        rd(ssr_pkg::SEL_GRP_EVENT, 16'h0002);
        rd(ssr_pkg::SEL_GRP_COND, 16'h0000);
        pulse(9);
        tick(2);
        rd(ssr_pkg::SEL_GRP_COND + 2, 16'h0002);
        pulse(10);
        tick(2);
        rd(ssr_pkg::SEL_GRP_COND + 2, 16'h0000);
        rd(ssr_pkg::SEL_GRP_COND + 1, 16'h0002);
        rd(ssr_pkg::SEL_OP_COND, 16'h0010);
        pulse(11);
        tick(2);
        rd(ssr_pkg::SEL_GRP_COND + 1, 16'h0000);
        rd(ssr_pkg::SEL_GRP_EVENT + 2, 16'h0002);
        rd(ssr_pkg::SEL_GRP_EVENT + 1, 16'h0002);
        rd(ssr_pkg::SEL_GRP_EVENT + 1, 16'h0000);
        pulse(9);
        pulse(10);
        pulse(12);
        tick(2);
        rd(ssr_pkg::SEL_GRP_COND + 1, 16'h0000);
        $display("Test activity groups finished");
        // Limit checking with boundary values
        for (int i = 0; i < 8; i++) begin
            lower_limit = -16'sd1 * 16'($urandom_range(0, 1000));
            upper_limit = 16'($urandom_range(0, 1000));
            meas_value = (i == 0) ? lower_limit : (i == 1) ? upper_limit
                : 16'($urandom_range(0, 2400)) - 16'sd1200;
            pulse(16);
            tick(2);
            e = lim_exp(meas_value, lower_limit, upper_limit);
            rd(ssr_pkg::SEL_GRP_COND + 4, {14'h0000, e[0], 1'b0});
            rd(ssr_pkg::SEL_GRP_COND + 5, {14'h0000, e[1], 1'b0});
        end
        meas_value = lower_limit;
        pulse(16);
        tick(2);
        pulse(1);
        meas_value = lower_limit - 16'sd1;
        pulse(16);
        tick(2);
        rd(ssr_pkg::SEL_OP_EVENT, 16'h0800);
        rd(ssr_pkg::SEL_GRP_EVENT + 4, 16'h0002);
        meas_value = upper_limit + 16'sd1;
        pulse(16);
        tick(2);
        rd(ssr_pkg::SEL_GRP_EVENT + 5, 16'h0002);
        $display("Test limits finished");
        summarize();
    end
endmodule
`default_nettype wire
